//--- shared/flash_status_pkg.sv
package flash_status_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;
  // Own register byte offsets on APB.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  // Control register fields.
  localparam int CTRL_GO = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_WRITE = 2;
  localparam int CTRL_READ = 3;
  // Status register fields.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RDY = 3;
  localparam int ST_ETIMER = 4;
  // Data bit positions on the flash data bus.
  localparam int BIT_POLL = 7;
  localparam int BIT_TOG1 = 6;
  localparam int BIT_TLIM = 5;
  localparam int BIT_ETMR = 3;
  localparam int BIT_TOG2 = 2;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  // Bus cycle timing.
  localparam int CLK_MHZ = 250;
  localparam int CYC_NS = 100;
  localparam int CYC_CLKS = (CYC_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
endpackage

//--- shared/flash_cyc_if.sv
`timescale 1ns/100ps
interface flash_cyc_if;
  import flash_status_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic done;
  modport master (output req, output wr, output addr, output wdata, input rdata, input done);
  modport slave (input req, input wr, input addr, input wdata, output rdata, output done);
endinterface

//--- logic/flash_bus_cycle.sv
`timescale 1ns/100ps
module flash_bus_cycle (
  input wire logic i_clk,
  input wire logic i_arst_n,
  flash_cyc_if.slave cyc,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [flash_status_pkg::ADDR_W-1:0] o_a,
  output logic [flash_status_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  input wire logic [flash_status_pkg::DATA_W-1:0] i_dq
);
  import flash_status_pkg::*;
  logic [CNT_W-1:0] cnt_q;
  logic act_q;
  logic [DATA_W-1:0] s1_q, s2_q;
  logic last;
  assign last = act_q && (cnt_q == CNT_W'(CYC_CLKS));
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= i_dq;
      s2_q <= s1_q;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      act_q <= 1'b0;
      cnt_q <= '0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_a <= '0;
      o_dq <= '0;
      o_dq_oe <= 1'b0;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= 1'b0;
      if (!act_q && cyc.req) begin
        act_q <= 1'b1;
        cnt_q <= '0;
        o_a <= cyc.addr;
        o_dq <= cyc.wdata;
        o_dq_oe <= cyc.wr;
        o_ce_n <= 1'b0;
        o_oe_n <= cyc.wr;
        o_we_n <= !cyc.wr;
      end else if (last) begin
        // The rising strobe ends the cycle; data was sampled through two stages.
        act_q <= 1'b0;
        o_ce_n <= 1'b1;
        o_oe_n <= 1'b1;
        o_we_n <= 1'b1;
        o_dq_oe <= 1'b0;
        cyc.rdata <= s2_q;
        cyc.done <= 1'b1;
      end else if (act_q) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule // flash_bus_cycle

//--- logic/flash_status_host.sv
`timescale 1ns/100ps
module flash_status_host (
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic [31:0] I_PADDR,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_CE_N,
  output logic O_OE_N,
  output logic O_WE_N,
  output logic [flash_status_pkg::ADDR_W-1:0] O_A,
  output logic [flash_status_pkg::DATA_W-1:0] O_DQ,
  output logic O_DQ_OE,
  input wire logic [flash_status_pkg::DATA_W-1:0] I_DQ,
  input wire logic I_READY_BUSY_OUT
);
  import flash_status_pkg::*;
  typedef enum {S_IDLE, S_WR, S_RD, S_RD1, S_RD2, S_RECHK, S_RST, S_FINAL} state_t;
  state_t st_q;
  flash_cyc_if cyc ();
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q, prev_q, rdat_q;
  logic mode_q, tlim_seen_q, done_q, fail_q, busy_q, etmr_q, req_q, wr_q;
  logic rb1_q, rb2_q;
  logic [ADDR_W-1:0] caddr_q;
  logic [DATA_W-1:0] cdata_q;
  logic acc, wr_ctrl, go, go_wr, go_rd, tog_same, poll_true, tlim, dbad;
  assign acc = I_PSEL && I_PENABLE;
  assign wr_ctrl = acc && I_PWRITE && (I_PADDR[7:0] == OFS_CTRL);
  assign go = wr_ctrl && I_PWDATA[CTRL_GO] && !busy_q;
  assign go_wr = wr_ctrl && I_PWDATA[CTRL_WRITE] && !busy_q;
  assign go_rd = wr_ctrl && I_PWDATA[CTRL_READ] && !busy_q;
  assign dbad = (I_PADDR > 32'(OFS_RDATA)) || (I_PADDR[1:0] != 2'b00);
  assign tog_same = cyc.rdata[BIT_TOG1] == prev_q[BIT_TOG1];
  assign poll_true = cyc.rdata[BIT_POLL] == data_q[BIT_POLL];
  assign tlim = cyc.rdata[BIT_TLIM];
  assign cyc.req = req_q;
  assign cyc.wr = wr_q;
  assign cyc.addr = caddr_q;
  assign cyc.wdata = cdata_q;
  flash_bus_cycle u_cyc (
    .i_clk(I_REF_CLK),
    .i_arst_n(I_ARST_N),
    .cyc(cyc),
    .o_ce_n(O_CE_N),
    .o_oe_n(O_OE_N),
    .o_we_n(O_WE_N),
    .o_a(O_A),
    .o_dq(O_DQ),
    .o_dq_oe(O_DQ_OE),
    .i_dq(I_DQ)
  );
  // The open-drain ready line comes from outside the clock domain.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rb1_q <= 1'b1;
      rb2_q <= 1'b1;
    end else begin
      rb1_q <= I_READY_BUSY_OUT;
      rb2_q <= rb1_q;
    end
  end
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PRDATA <= '0;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
    end else begin
      // Ready follows every setup cycle, so each access has exactly one access cycle.
      O_PREADY <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && dbad;
      // Writes while busy are dropped so a running poll keeps its address and data.
      if (acc && I_PWRITE && I_PADDR[7:0] == OFS_ADDR && !busy_q) begin
        addr_q <= I_PWDATA[ADDR_W-1:0];
      end
      if (acc && I_PWRITE && I_PADDR[7:0] == OFS_DATA && !busy_q) begin
        data_q <= I_PWDATA[DATA_W-1:0];
      end
      case (I_PADDR[7:0])
        OFS_ADDR: O_PRDATA <= 32'(addr_q);
        OFS_DATA: O_PRDATA <= 32'(data_q);
        OFS_CTRL: O_PRDATA <= {31'h0, mode_q} << CTRL_MODE;
        OFS_STATUS: O_PRDATA <= {27'h0, etmr_q, rb2_q, fail_q, done_q, busy_q};
        OFS_RDATA: O_PRDATA <= 32'(rdat_q);
        default: O_PRDATA <= '0;
      endcase
    end
  end
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_q <= S_IDLE;
      mode_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      etmr_q <= 1'b0;
      tlim_seen_q <= 1'b0;
      prev_q <= '0;
      rdat_q <= '0;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      caddr_q <= '0;
      cdata_q <= '0;
    end else begin
      req_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (go_wr || go_rd) begin
            busy_q <= 1'b1;
            req_q <= 1'b1;
            wr_q <= go_wr;
            caddr_q <= addr_q;
            cdata_q <= data_q;
            st_q <= go_wr ? S_WR : S_RD;
          end else if (go) begin
            // Polling starts after software has written the full command.
            mode_q <= I_PWDATA[CTRL_MODE];
            busy_q <= 1'b1;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            tlim_seen_q <= 1'b0;
            req_q <= 1'b1;
            wr_q <= 1'b0;
            caddr_q <= addr_q;
            st_q <= S_RD1;
          end
        end
        // Single cycles let software issue the device's command sequences itself.
        S_WR, S_RD: begin
          if (cyc.done) begin
            rdat_q <= cyc.rdata;
            busy_q <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        S_RD1: begin
          if (cyc.done) begin
            prev_q <= cyc.rdata;
            req_q <= 1'b1;
            st_q <= S_RD2;
          end
        end
        S_RD2: begin
          if (cyc.done) begin
            // Each read becomes the reference for the next, so read pairs overlap.
            etmr_q <= cyc.rdata[BIT_ETMR];
            prev_q <= cyc.rdata;
            req_q <= 1'b1;
            if (mode_q ? tog_same : poll_true) begin
              st_q <= S_FINAL;
            end else if (tlim) begin
              tlim_seen_q <= 1'b1;
              st_q <= S_RECHK;
            end
          end
        end
        S_RECHK: begin
          // The flag and the status bit can switch together, so one more read decides.
          if (cyc.done) begin
            prev_q <= cyc.rdata;
            req_q <= 1'b1;
            if (mode_q ? tog_same : poll_true) begin
              st_q <= S_FINAL;
            end else begin
              fail_q <= 1'b1;
              wr_q <= 1'b1;
              cdata_q <= CMD_RESET;
              st_q <= S_RST;
            end
          end
        end
        S_RST: begin
          if (cyc.done) begin
            wr_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_FINAL: begin
          if (cyc.done) begin
            rdat_q <= cyc.rdata;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // flash_status_host

//--- verification/flash_dev_model.sv
`timescale 1ns/100ps
module flash_dev_model #(
  parameter int BUSY_READS = 5,
  parameter int ERASE_READS = 8
) (
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [7:0] i_dq,
  input wire logic i_stuck,
  input wire logic i_prot,
  output logic [7:0] o_dq,
  output logic o_ready_busy,
  output int o_resets
);
  logic [7:0] mem_q = 8'hff;
  logic [7:0] pd_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic armed_q = 1'b0;
  logic tog_q = 1'b0;
  logic tog2_q = 1'b0;
  logic stuck_q = 1'b0;
  logic ers_q = 1'b0;
  logic susp_q = 1'b0;
  logic ers_prot_q = 1'b0;
  int left_q = 0;
  int ers_left_q = 0;
  // A cycle ends at whichever of chip select and its strobe rises first.
  wire wr_on = (i_ce_n === 1'b0) && (i_we_n === 1'b0);
  wire rd_on = (i_ce_n === 1'b0) && (i_oe_n === 1'b0);
  wire prog = (left_q > 0) || stuck_q;
  wire ers_run = ers_q && !susp_q;
  wire busy = prog || ers_run;
  wire [7:0] seen = prog ? {~pd_q[7], tog_q, stuck_q, 5'h00} :
    ers_run ? {1'b0, tog_q, 2'b00, 1'b1, tog2_q, 2'b00} :
    ers_q ? {1'b1, tog_q, 3'b000, tog2_q, 2'b00} : mem_q;
  // A released bus shows the inverse of the last byte so stale data never passes.
  assign o_dq = rd_on ? seen : ~last_q;
  assign o_ready_busy = !busy;
  initial o_resets = 0;
  always @(negedge wr_on) begin
    if (i_dq == 8'hf0) begin
      left_q = 0;
      ers_left_q = 0;
      stuck_q = 1'b0;
      armed_q = 1'b0;
      ers_q = 1'b0;
      susp_q = 1'b0;
      o_resets++;
    end else if (armed_q) begin
      pd_q = i_dq;
      mem_q = (i_stuck || i_prot) ? mem_q : i_dq;
      left_q = BUSY_READS;
      stuck_q = i_stuck;
      armed_q = 1'b0;
    end else if (i_dq == 8'h30 && susp_q) begin
      susp_q = 1'b0;
    end else if (i_dq == 8'hb0 && ers_run) begin
      susp_q = 1'b1;
    end else if ((i_dq == 8'h10 || i_dq == 8'h30) && !ers_q) begin
      ers_q = 1'b1;
      ers_prot_q = i_prot;
      ers_left_q = ERASE_READS;
    end else begin
      armed_q = (i_dq == 8'ha0);
    end
  end
  always @(negedge rd_on) begin
    last_q = seen;
    tog_q = busy ? !tog_q : tog_q;
    tog2_q = ers_q ? !tog2_q : tog2_q;
    if (left_q > 0) begin
      left_q = left_q - 1;
    end else if (ers_run) begin
      ers_left_q = ers_left_q - 1;
      if (ers_left_q <= 0) begin
        ers_q = 1'b0;
        mem_q = ers_prot_q ? mem_q : 8'hff;
      end
    end
  end
endmodule // flash_dev_model

//--- verification/flash_status_host_props.sv
`timescale 1ns/100ps
module flash_status_host_props (
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic [31:0] I_PADDR,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_CE_N,
  input wire logic O_OE_N,
  input wire logic O_WE_N,
  input wire logic [flash_status_pkg::ADDR_W-1:0] O_A,
  input wire logic O_DQ_OE
);
  import flash_status_pkg::*;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);
  chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready too long");
  chk_ready_after_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("ready late");
  chk_ready_in_access: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
    else $error("ready outside access");
  chk_error_unmapped: assert property (O_PREADY && I_PADDR > 32'h10 |-> O_PSLVERR)
    else $error("no error on unmapped");
  chk_no_contention: assert property (!O_OE_N |-> !O_DQ_OE && O_WE_N)
    else $error("bus contention");
  chk_write_selected: assert property (!O_WE_N |-> !O_CE_N && O_DQ_OE)
    else $error("write unselected");
  chk_read_width: assert property ($fell(O_OE_N) |-> !O_OE_N [*8])
    else $error("read strobe short");
  chk_addr_hold: assert property (!O_CE_N && !$past(O_CE_N) |-> $stable(O_A))
    else $error("address moved");
  cover property ($fell(O_WE_N));
  cover property ($fell(O_OE_N));
  cover property (O_PREADY && O_PSLVERR);
endmodule // flash_status_host_props
bind flash_status_host flash_status_host_props i_props (.I_REF_CLK(I_REF_CLK),
  .I_ARST_N(I_ARST_N), .I_PADDR(I_PADDR), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_CE_N(O_CE_N), .O_OE_N(O_OE_N),
  .O_WE_N(O_WE_N), .O_A(O_A), .O_DQ_OE(O_DQ_OE));

//--- verification/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import flash_status_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stuck = 1'b0, prot = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ce_n, oe_n, we_n, dq_oe, rb, err;
  logic [ADDR_W-1:0] fa;
  logic [DATA_W-1:0] hdq, mdq;
  logic [7:0] pat [2] = '{8'h5a, 8'ha5};
  int bad_count = 0;
  int compares = 0;
  int resets;
  always #2 clk = ~clk;
  flash_status_host i_dut (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_PADDR(paddr), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_CE_N(ce_n), .O_OE_N(oe_n), .O_WE_N(we_n),
    .O_A(fa), .O_DQ(hdq), .O_DQ_OE(dq_oe), .I_DQ(dq_oe ? hdq : mdq), .I_READY_BUSY_OUT(rb));
  flash_dev_model #(.BUSY_READS(5), .ERASE_READS(8)) i_flash (.i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_dq(hdq), .i_stuck(stuck), .i_prot(prot), .o_dq(mdq),
    .o_ready_busy(rb), .o_resets(resets));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Starts one controller operation and waits, bounded, until it is no longer busy.
  task automatic op(input logic [31:0] ctrl, input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, OFS_ADDR, a);
    apb(1'b1, OFS_DATA, d);
    apb(1'b1, OFS_CTRL, ctrl);
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if (rd[ST_BUSY] === 1'b0) break;
    end
  endtask
  task automatic unlock;
    op(32'h4, 32'h0, 32'haa);
    op(32'h4, 32'h0, 32'h55);
  endtask
  task automatic prog_byte(input logic [31:0] a, input logic [31:0] d);
    unlock();
    op(32'h4, 32'h0, 32'ha0);
    op(32'h4, a, d);
  endtask
  task automatic erase_chip;
    unlock();
    op(32'h4, 32'h0, 32'h80);
    unlock();
    op(32'h4, 32'h0, 32'h10);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[3:0], 4'h8)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(err, 1'b1)
    for (int m = 0; m < 2; m++) begin
      prog_byte(32'h123 + m, {24'h0, pat[m]});
      op(32'h1 | (m << 1), 32'h123 + m, {24'h0, pat[m]});
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[2:0], 3'b010)
      apb(1'b0, OFS_RDATA, 32'h0);
      `CHK(rd[7:0], pat[m])
    end
    op(32'h8, 32'h124, 32'h0);
    apb(1'b0, OFS_RDATA, 32'h0);
    `CHK(rd[7:0], 8'ha5)
    stuck <= 1'b1;
    prog_byte(32'h200, 32'h33);
    stuck <= 1'b0;
    op(32'h3, 32'h200, 32'h33);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK({rd[ST_RDY], rd[ST_FAIL], rd[ST_BUSY]}, 3'b110)
    `CHK(resets, 1)
    prot <= 1'b1;
    prog_byte(32'h300, 32'h0f);
    op(32'h3, 32'h300, 32'h0f);
    apb(1'b0, OFS_RDATA, 32'h0);
    `CHK(rd[7:0], 8'ha5)
    erase_chip();
    prot <= 1'b0;
    op(32'h3, 32'h0, 32'hff);
    apb(1'b0, OFS_RDATA, 32'h0);
    `CHK(rd[7:0], 8'ha5)
    erase_chip();
    op(32'h4, 32'h0, 32'hb0);
    op(32'h3, 32'h0, 32'hff);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[3:0], 4'b1010)
    apb(1'b0, OFS_RDATA, 32'h0);
    `CHK(rd[7], 1'b1)
    op(32'h4, 32'h0, 32'h30);
    op(32'h1, 32'h0, 32'hff);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[4:0], 5'b11010)
    apb(1'b0, OFS_RDATA, 32'h0);
    `CHK(rd[7:0], 8'hff)
    end_of_test();
  end
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
endmodule // tb_top
